/* File: hw/fcu_pkg.sv */
package fcu_pkg;
  localparam int NUM_FAULTS = 8;
  localparam int SRC_W = 3;
  localparam int ADR_W = 8;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_FSTAT = 8'h08;
  localparam logic [7:0] ADR_IMASK = 8'h0c;
  localparam logic [7:0] ADR_FSRC = 8'h10;
  localparam logic [7:0] ADR_HOLD = 8'h14;

  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_POL = 3;
  localparam int CTRL_SLOW = 4;
  localparam int CTRL_DEVRST = 5;
  localparam int CTRL_TEST_LO = 6;
  localparam int STAT_ERR = 0;
  localparam int STAT_STATE_LO = 1;
  localparam int FSRC_VALID = 8;

  localparam logic [31:0] HOLD_RESET = 32'h0000_0400;
  localparam logic [7:0] IMASK_RESET = 8'h00;

  localparam int CLK_PERIOD_PS = 8000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int REF_PERIOD_PS = 62500;
  localparam int FAULT_REACH_REF = 10;
  localparam int FAULT_REACH_CYCLES = FAULT_REACH_REF * REF_PERIOD_PS / CLK_PERIOD_PS;
  localparam int SEMI_PERIOD_NS = 8200000;
  localparam int SEMI_CYCLES_DEF = SEMI_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_FAULT = 2'b00,
    ST_HOLD = 2'b01,
    ST_NORMAL = 2'b10
  } fcu_state_t;

  typedef enum logic [1:0] {
    MODE_DUAL = 2'b00,
    MODE_TIME = 2'b01,
    MODE_BISTABLE = 2'b10,
    MODE_TEST = 2'b11
  } fcu_mode_t;
endpackage

/* File: hw/fcu_pin_if.sv */
`timescale 1ns/1ps
interface fcu_pin_if;
  import fcu_pkg::*;
  logic enable;
  logic slow;
  logic pol;
  fcu_mode_t mode;
  logic [1:0] test_val;
  logic operational;
  logic shown_op;
  logic [1:0] pins;
  logic [1:0] oe;
  modport ctl (output enable, slow, pol, mode, test_val, operational,
    input shown_op, pins, oe);
  modport gen (input enable, slow, pol, mode, test_val, operational,
    output shown_op, pins, oe);
endinterface

/* File: hw/fcu_fault_capture.sv */
`timescale 1ns/1ps
module fcu_fault_capture
  import fcu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  input wire logic [NUM_FAULTS-1:0] clr,
  input wire logic arm,
  output logic [NUM_FAULTS-1:0] status,
  output logic [SRC_W-1:0] src_idx,
  output logic src_valid
);
  logic [NUM_FAULTS-1:0] status_reg, status_next;
  logic [SRC_W-1:0] src_reg, src_next;
  logic valid_reg, valid_next;

  function automatic logic [SRC_W-1:0] lowest(input logic [NUM_FAULTS-1:0] v);
    logic [SRC_W-1:0] r;
    r = '0;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (v[i]) r = SRC_W'(i);
    end
    return r;
  endfunction

  always_comb begin
    // set wins over a simultaneous clear
    status_next = (status_reg & ~clr) | fault_in;
    src_next = src_reg;
    valid_next = valid_reg;
    if (arm && |fault_in) begin
      src_next = lowest(fault_in);
      valid_next = 1'b1;
    end
  end

  // only power-on reset clears the recorded source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= '0;
      src_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      src_reg <= src_next;
      valid_reg <= valid_next;
    end
  end

  assign status = status_reg;
  assign src_idx = src_reg;
  assign src_valid = valid_reg;
endmodule

/* File: hw/fcu_pin_gen.sv */
`timescale 1ns/1ps
module fcu_pin_gen
  import fcu_pkg::*;
#(
  parameter int unsigned SEMI_CYCLES = SEMI_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  fcu_pin_if.gen pif
);
  logic [31:0] cnt_reg, cnt_next;
  logic phase_reg, phase_next;
  logic shown_reg, shown_next;
  logic [1:0] pins_reg, pins_next;
  logic [1:0] oe_reg, oe_next;
  logic tick;
  logic op;

  always_comb begin
    tick = (cnt_reg == 32'(SEMI_CYCLES - 1));
    cnt_next = tick ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
    phase_next = tick ? ~phase_reg : phase_reg;
    // outside bi-stable mode, slow switching changes the shown state only at a half-period edge
    shown_next = shown_reg;
    if (!pif.slow || pif.mode == MODE_BISTABLE || tick) begin
      shown_next = pif.operational;
    end
    op = shown_reg;
    unique case (pif.mode)
      MODE_DUAL: pins_next = op ? {~phase_reg, phase_reg} : 2'b00;
      MODE_TIME: pins_next = op ? {1'b1, phase_reg} : 2'b00;
      MODE_BISTABLE: pins_next = (op ^ pif.pol) ? 2'b01 : 2'b10;
      MODE_TEST: pins_next = pif.test_val;
    endcase
    oe_next = {2{pif.enable}};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0000_0000;
      phase_reg <= 1'b0;
      shown_reg <= 1'b0;
      pins_reg <= 2'b00;
      oe_reg <= 2'b00;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      shown_reg <= shown_next;
      pins_reg <= pins_next;
      oe_reg <= oe_next;
    end
  end

  assign pif.shown_op = shown_reg;
  assign pif.pins = pins_reg;
  assign pif.oe = oe_reg;
endmodule

/* File: hw/fcu_top.sv */
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module fcu_top #(
  parameter int unsigned SEMI_CYCLES = fcu_pkg::SEMI_CYCLES_DEF
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [fcu_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [fcu_pkg::NUM_FAULTS-1:0] FAULT_IN,
  output logic [1:0] ERROR_OUT_PINS_O,
  output logic [1:0] ERROR_OUT_PINS_OE,
  output logic SAFE_STATE,
  output logic DEVICE_RESET_REQ,
  output logic IRQ
);
  import fcu_pkg::*;

  localparam int REACH_MAX = FAULT_REACH_CYCLES;

  fcu_state_t state_reg, state_next;
  logic [31:0] hold_cnt_reg, hold_cnt_next;
  logic [31:0] hold_len_reg, hold_len_next;
  logic en_reg, en_next;
  fcu_mode_t mode_reg, mode_next;
  logic pol_reg, pol_next;
  logic slow_reg, slow_next;
  logic [1:0] test_reg, test_next;
  logic [NUM_FAULTS-1:0] mask_reg, mask_next;
  logic devrst_reg, devrst_next;
  logic irq_reg, irq_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;

  logic req, wr_go;
  logic fault_any;
  logic flag_wr, flag_set, flag_clr;
  logic [NUM_FAULTS-1:0] fstat_clr;
  logic [NUM_FAULTS-1:0] fstat;
  logic [SRC_W-1:0] src_idx;
  logic src_valid;
  logic [31:0] ctrl_word;

  fcu_pin_if pif ();

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] offs);
    return {adr[ADR_W-1:2], 2'b00} == offs;
  endfunction

  fcu_fault_capture u_capture (
    .clk(CLK),
    .rst(RESET),
    .fault_in(FAULT_IN),
    .clr(fstat_clr),
    .arm(state_reg != ST_FAULT),
    .status(fstat),
    .src_idx(src_idx),
    .src_valid(src_valid)
  );

  fcu_pin_gen #(.SEMI_CYCLES(SEMI_CYCLES)) u_pins (
    .clk(CLK),
    .rst(RESET),
    .pif(pif)
  );

  assign pif.enable = en_reg;
  assign pif.slow = slow_reg;
  assign pif.pol = pol_reg;
  assign pif.mode = mode_reg;
  assign pif.test_val = test_reg;
  assign pif.operational = (state_reg == ST_NORMAL);

  // bus decode; a write lands on the edge where ack is seen high
  always_comb begin
    req = WB_CYC_I && WB_STB_I;
    wr_go = req && WB_WE_I && ack_reg;
    fault_any = |FAULT_IN;
    flag_wr = wr_go && hit(WB_ADR_I, ADR_STAT) && WB_SEL_I[0];
    flag_set = flag_wr && WB_DAT_I[STAT_ERR];
    flag_clr = flag_wr && !WB_DAT_I[STAT_ERR];
    fstat_clr = '0;
    if (wr_go && hit(WB_ADR_I, ADR_FSTAT) && WB_SEL_I[0]) begin
      fstat_clr = WB_DAT_I[NUM_FAULTS-1:0];
    end
    ctrl_word = '0;
    ctrl_word[CTRL_EN] = en_reg;
    ctrl_word[CTRL_MODE_LO +: 2] = mode_reg;
    ctrl_word[CTRL_POL] = pol_reg;
    ctrl_word[CTRL_SLOW] = slow_reg;
    ctrl_word[CTRL_TEST_LO +: 2] = test_reg;
  end

  // safety state machine
  always_comb begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    unique case (state_reg)
      ST_NORMAL: begin
        if (fault_any || flag_set) state_next = ST_FAULT;
      end
      ST_FAULT: begin
        // release needs no live fault and all recorded faults cleared
        if (!fault_any && flag_clr && fstat == '0) begin
          state_next = ST_HOLD;
          hold_cnt_next = hold_len_reg;
        end
      end
      ST_HOLD: begin
        if (fault_any || flag_set) begin
          state_next = ST_FAULT;
        end else if (hold_cnt_reg == 32'h0000_0000) begin
          state_next = ST_NORMAL;
        end else begin
          hold_cnt_next = hold_cnt_reg - 32'h0000_0001;
        end
      end
      default: state_next = ST_FAULT;
    endcase
  end

  // registers and bus answer
  always_comb begin
    en_next = en_reg;
    mode_next = mode_reg;
    pol_next = pol_reg;
    slow_next = slow_reg;
    test_next = test_reg;
    mask_next = mask_reg;
    hold_len_next = hold_len_reg;
    devrst_next = 1'b0;
    if (wr_go && hit(WB_ADR_I, ADR_CTRL) && WB_SEL_I[0]) begin
      en_next = WB_DAT_I[CTRL_EN];
      mode_next = fcu_mode_t'(WB_DAT_I[CTRL_MODE_LO +: 2]);
      pol_next = WB_DAT_I[CTRL_POL];
      slow_next = WB_DAT_I[CTRL_SLOW];
      test_next = WB_DAT_I[CTRL_TEST_LO +: 2];
      devrst_next = WB_DAT_I[CTRL_DEVRST];
    end
    if (wr_go && hit(WB_ADR_I, ADR_IMASK) && WB_SEL_I[0]) begin
      mask_next = WB_DAT_I[NUM_FAULTS-1:0];
    end
    if (wr_go && hit(WB_ADR_I, ADR_HOLD)) begin
      hold_len_next = lane_merge(hold_len_reg, WB_DAT_I, WB_SEL_I);
    end
    irq_next = |(fstat & mask_reg);
    ack_next = req && !ack_reg;
    rdat_next = rdat_reg;
    if (ack_next) begin
      rdat_next = '0;
      if (hit(WB_ADR_I, ADR_CTRL)) rdat_next = ctrl_word;
      if (hit(WB_ADR_I, ADR_STAT)) begin
        rdat_next[STAT_ERR] = (state_reg != ST_NORMAL);
        rdat_next[STAT_STATE_LO +: 2] = state_reg;
      end
      if (hit(WB_ADR_I, ADR_FSTAT)) rdat_next[NUM_FAULTS-1:0] = fstat;
      if (hit(WB_ADR_I, ADR_IMASK)) rdat_next[NUM_FAULTS-1:0] = mask_reg;
      if (hit(WB_ADR_I, ADR_FSRC)) begin
        rdat_next[SRC_W-1:0] = src_idx;
        rdat_next[FSRC_VALID] = src_valid;
      end
      if (hit(WB_ADR_I, ADR_HOLD)) rdat_next = hold_len_reg;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= ST_FAULT;
      hold_cnt_reg <= 32'h0000_0000;
      hold_len_reg <= HOLD_RESET;
      en_reg <= 1'b0;
      mode_reg <= MODE_DUAL;
      pol_reg <= 1'b0;
      slow_reg <= 1'b0;
      test_reg <= 2'b00;
      mask_reg <= IMASK_RESET;
      devrst_reg <= 1'b0;
      irq_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      hold_len_reg <= hold_len_next;
      en_reg <= en_next;
      mode_reg <= mode_next;
      pol_reg <= pol_next;
      slow_reg <= slow_next;
      test_reg <= test_next;
      mask_reg <= mask_next;
      devrst_reg <= devrst_next;
      irq_reg <= irq_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdat_reg;
  assign ERROR_OUT_PINS_O = pif.pins;
  assign ERROR_OUT_PINS_OE = pif.oe;
  assign SAFE_STATE = (state_reg != ST_NORMAL);
  assign DEVICE_RESET_REQ = devrst_reg;
  assign IRQ = irq_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_SAFE_ON_FAULT: assert property (fault_any |=> state_reg == ST_FAULT)
    else $error("fault did not enter fault state");
  AST_TWO_PINS: assert property (ERROR_OUT_PINS_OE == {2{$past(en_reg)}})
    else $error("pin enables do not follow enable");
  AST_MODE_TEST: assert property (
    (en_reg && mode_reg == MODE_TEST && $stable(test_reg)) [*2]
    |-> ERROR_OUT_PINS_O == test_reg)
    else $error("test mode pins wrong");
  AST_RESET_SAFE: assert property ($past(RESET) |->
    ERROR_OUT_PINS_OE == 2'b00 && state_reg == ST_FAULT)
    else $error("pins not safe after reset");
  AST_FLAG_READ: assert property (
    (WB_ACK_O && hit($past(WB_ADR_I), ADR_STAT) && !$past(WB_WE_I))
    |-> WB_DAT_O[STAT_ERR] == $past(SAFE_STATE))
    else $error("error flag read wrong");
  AST_FLAG_SET: assert property (flag_set |=> state_reg == ST_FAULT)
    else $error("flag write 1 did not force fault");
  AST_NO_AUTO_OP: assert property (
    state_reg == ST_HOLD && $past(state_reg) == ST_FAULT |-> $past(flag_clr))
    else $error("release without software request");
  AST_OP_HIGH: assert property (
    (pif.shown_op && en_reg && mode_reg != MODE_TEST) |=> ERROR_OUT_PINS_O != 2'b00)
    else $error("operational with both pins low");
  AST_BISTABLE: assert property (
    mode_reg == MODE_BISTABLE |=>
    ERROR_OUT_PINS_O == (($past(pif.shown_op) ^ $past(pol_reg)) ? 2'b01 : 2'b10))
    else $error("bi-stable pins wrong");
  AST_SRC_KEPT: assert property (
    src_valid && state_reg == ST_FAULT |=> $stable(src_idx) && src_valid)
    else $error("fault source lost");
  AST_HOLD_TIME: assert property (
    (state_reg == ST_HOLD && hold_cnt_reg != 32'h0000_0000) |=>
    state_reg != ST_NORMAL)
    else $error("hold time cut short");
  AST_DEV_RESET: assert property (
    (wr_go && hit(WB_ADR_I, ADR_CTRL) && WB_SEL_I[0] && WB_DAT_I[CTRL_DEVRST])
    |=> DEVICE_RESET_REQ ##1 !DEVICE_RESET_REQ)
    else $error("device reset request missing");
  AST_REACH: assert property ($rose(fault_any) |-> ##[1:REACH_MAX] SAFE_STATE)
    else $error("fault not collected in time");
  AST_FAST_SHOW: assert property (
    (!pif.operational && en_reg && !slow_reg && mode_reg inside {MODE_DUAL, MODE_TIME})
    [*3] |-> ERROR_OUT_PINS_O == 2'b00)
    else $error("fast failure indication late");
  AST_RELEASE: assert property (
    $rose(state_reg == ST_NORMAL) |-> $past(state_reg) == ST_HOLD)
    else $error("operational entered without hold");

  COV_OPERATIONAL: cover property ($rose(state_reg == ST_NORMAL));
  COV_HOLD_ABORT: cover property (state_reg == ST_HOLD ##1 state_reg == ST_FAULT);
  COV_DEV_RESET: cover property (DEVICE_RESET_REQ);
  COV_IRQ: cover property ($rose(IRQ));
endmodule

/* File: tb/fcu_safety_monitor.sv */
`timescale 1ns/1ps
module fcu_safety_monitor (
  input wire logic clk,
  input wire logic [1:0] pins_o,
  input wire logic [1:0] pins_oe,
  output logic [1:0] line,
  output logic healthy
);
  logic [1:0] last_reg;
  initial last_reg = 2'b00;
  // no pull on the wires: an undriven line flips every cycle
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      line[i] = pins_oe[i] ? pins_o[i] : ~last_reg[i];
    end
  end
  always @(posedge clk) begin
    last_reg <= line;
  end
  assign healthy = |(pins_oe & line);
endmodule

/* File: tb/fault_error_output_indicator_bench.sv */
`timescale 1ns/1ps
module fault_error_output_indicator_bench;
  import fcu_pkg::*;
  logic clk, reset, cyc, stb, we, ack, safe, dev_rst, irq, healthy;
  logic [7:0] adr, fault_in;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, q;
  logic [1:0] pins_o, pins_oe, line;
  int fails = 0;
  int total_checks = 0;
  int pulses = 0;
  int n;

  fcu_top #(.SEMI_CYCLES(8)) dut (.CLK(clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
    .WB_ACK_O(ack), .FAULT_IN(fault_in), .ERROR_OUT_PINS_O(pins_o),
    .ERROR_OUT_PINS_OE(pins_oe), .SAFE_STATE(safe), .DEVICE_RESET_REQ(dev_rst), .IRQ(irq));
  fcu_safety_monitor mon (.clk(clk), .pins_o(pins_o), .pins_oe(pins_oe), .line(line),
    .healthy(healthy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (dev_rst === 1'b1) pulses++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one classic cycle; called right after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      fails++;
      summarize();
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask

  task automatic wait_safe(input logic v);
    n = 0;
    while (safe !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (safe !== v) begin
      fails++;
      summarize();
    end
  endtask

  task automatic t_reset();
    check(safe, 1);
    check(pins_oe, 0);
    check(healthy, 0);
    rd(ADR_STAT, 32'h0000_0001);
    rd(ADR_HOLD, HOLD_RESET);
    rd(ADR_IMASK, 32'h0000_0000);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0000_0000);
  endtask

  task automatic t_enable();
    wr(ADR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
    check(pins_oe, 2'b11);
    check(pins_o, 2'b00);
    repeat (20) @(posedge clk);
    check(safe, 1);
  endtask

  task automatic t_release();
    wr(ADR_HOLD, 32'h0000_0005);
    wr(ADR_STAT, 32'h0000_0000);
    check(safe, 1);
    wait_safe(1'b0);
    check(n, 6);
    repeat (3) @(posedge clk);
    rd(ADR_STAT, 32'h0000_0004);
    repeat (16) begin
      @(posedge clk);
      check(healthy, 1);
    end
    wr(ADR_CTRL, 32'h0000_0003);
    repeat (16) begin
      @(posedge clk);
      check(pins_o[1], 1);
    end
    wr(ADR_CTRL, 32'h0000_0001);
  endtask

  task automatic t_fault();
    wr(ADR_IMASK, 32'h0000_0008);
    check(irq, 0);
    fault_in <= 8'h48;
    @(posedge clk);
    fault_in <= 8'h00;
    @(posedge clk);
    #1 check(safe, 1);
    repeat (3) @(posedge clk);
    check(pins_o, 2'b00);
    check(irq, 1);
    rd(ADR_FSRC, 32'h0000_0103);
    rd(ADR_FSTAT, 32'h0000_0048);
    wr(ADR_STAT, 32'h0000_0000);
    repeat (12) @(posedge clk);
    rd(ADR_STAT, 32'h0000_0001);
    wr(ADR_FSTAT, 32'h0000_0048);
    repeat (2) @(posedge clk);
    check(irq, 0);
    wr(ADR_STAT, 32'h0000_0000);
    wait_safe(1'b0);
    rd(ADR_FSRC, 32'h0000_0103);
  endtask

  task automatic t_bistable();
    for (int p = 0; p < 2; p++) begin
      wr(ADR_CTRL, 32'h0000_0005 | (p << 3));
      repeat (3) @(posedge clk);
      check(pins_o, p ? 2'b10 : 2'b01);
    end
    wr(ADR_STAT, 32'h0000_0001);
    check(safe, 1);
    repeat (3) @(posedge clk);
    check(pins_o, 2'b01);
  endtask

  task automatic t_test_devrst();
    wr(ADR_CTRL, 32'h0000_0087);
    repeat (3) @(posedge clk);
    check(pins_o, 2'b10);
    wr(ADR_CTRL, 32'h0000_0047);
    repeat (3) @(posedge clk);
    check(pins_o, 2'b01);
    pulses = 0;
    wr(ADR_CTRL, 32'h0000_0021);
    repeat (3) @(posedge clk);
    check(pulses, 1);
    rd(ADR_CTRL, 32'h0000_0001);
  endtask

  // slow dual rail: failure shows only at the half-period edge after the fault
  task automatic t_slow();
    logic [1:0] prev;
    wr(ADR_CTRL, 32'h0000_0011);
    rd(ADR_CTRL, 32'h0000_0011);
    wr(ADR_STAT, 32'h0000_0000);
    wait_safe(1'b0);
    check(pins_o, 2'b00);
    prev = pins_o;
    n = 0;
    while (pins_o === prev && n < 20) begin
      @(posedge clk);
      n++;
    end
    check(pins_o != 2'b00, 1);
    fault_in <= 8'h01;
    @(posedge clk);
    fault_in <= 8'h00;
    repeat (6) @(posedge clk);
    check(pins_o != 2'b00, 1);
    @(posedge clk);
    check(pins_o, 2'b00);
  endtask

  initial begin
    reset = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
    fault_in = 8'h00;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_enable();
    t_release();
    t_fault();
    t_bistable();
    t_test_devrst();
    t_slow();
    summarize();
  end
endmodule
